// ===== hw/crs_consts.vh
// Constants for the CPU register set block
`ifndef CRS_CONSTS_VH
`define CRS_CONSTS_VH
`define CRS_CPU_MODE_ADDR   16'h003b
`define CRS_STACK_PAGE_BIT  2
`define CRS_PAGE0_HIGH      8'h00
`define CRS_PAGE1_HIGH      8'h01
`define CRS_SP_RESET        8'hff
`define CRS_PC_RESET        16'h0000
`define CRS_MODE_RESET      8'h00
// Operation codes on opSel
`define CRS_OP_NONE   4'h0
`define CRS_OP_LDA    4'h1
`define CRS_OP_LDX    4'h2
`define CRS_OP_LDY    4'h3
`define CRS_OP_LDSP   4'h4
`define CRS_OP_PHA    4'h5
`define CRS_OP_PHP    4'h6
`define CRS_OP_PLA    4'h7
`define CRS_OP_PLP    4'h8
`define CRS_OP_MUL    4'h9
`define CRS_OP_DIV    4'ha
`define CRS_OP_STOP   4'hb
`define CRS_OP_WAIT   4'hc
`define CRS_OP_FAST   4'hd
`define CRS_OP_SLOW   4'he
`define CRS_OP_JUMP   4'hf
`endif

// ===== hw/crs_cpu_register_set.v
// CPU register set: A, X, Y, stack pointer, PC and mode register
`include "crs_consts.vh"
module crs_cpu_register_set (
   input  wire        ref_clk,
   input  wire        reset,
   input  wire [3:0]  opSel,
   input  wire [7:0]  loadData,
   input  wire [7:0]  statusIn,
   input  wire [7:0]  operand,
   input  wire        pcIncrement,
   input  wire        pcLoad,
   input  wire [15:0] pcLoadValue,
   input  wire        modeWrite,
   input  wire [15:0] modeWriteAddr,
   input  wire [7:0]  modeWriteData,
   input  wire [7:0]  memReadData,
   output reg  [7:0]  accumulator_ff,
   output reg  [7:0]  indexX_ff,
   output reg  [7:0]  indexY_ff,
   output reg  [7:0]  stackPtr_ff,
   output reg  [7:0]  statusOut_ff,
   output reg  [7:0]  cpuModeReg_ff,
   output wire [7:0]  pcHighByte,
   output wire [7:0]  pcLowByte,
   output wire [15:0] stackAddr,
   output wire [15:0] indexedAddrX,
   output wire [15:0] indexedAddrY,
   output wire        memWrite,
   output wire [7:0]  memWriteData,
   output wire        memRead,
   output reg         illegalOp_ff,
   output reg         stopReq_ff,
   output reg         waitReq_ff,
   output reg  [15:0] mulDivResult_ff
);
   reg  [15:0] progCount_ff;
   reg  [15:0] nxt_progCount;
   reg  [7:0]  nxt_accumulator;
   reg  [7:0]  nxt_indexX;
   reg  [7:0]  nxt_indexY;
   reg  [7:0]  nxt_stackPtr;
   reg  [7:0]  nxt_statusOut;
   reg  [7:0]  nxt_cpuModeReg;
   reg         nxt_illegalOp;
   reg         nxt_stopReq;
   reg         nxt_waitReq;
   reg  [15:0] nxt_mulDivResult;
   wire        isPush;
   wire        isPop;
   wire        pageSel;
   wire        divZero;
   wire        modeHit;
   wire [7:0]  spPlusOne;
   wire [7:0]  spMinusOne;
   wire [7:0]  stackLow;
   wire [15:0] productFull;
   wire [15:0] divideFull;

   // Page select taken from mode register
   assign pageSel = cpuModeReg_ff[`CRS_STACK_PAGE_BIT];
   assign spPlusOne  = stackPtr_ff + 8'h01;
   assign spMinusOne = stackPtr_ff - 8'h01;
   // Pop pre-increments, so its address already sits one above the pointer
   assign stackLow = isPop ? spPlusOne : stackPtr_ff;
   assign stackAddr = {(pageSel ? `CRS_PAGE1_HIGH : `CRS_PAGE0_HIGH),
                       stackLow};
   assign indexedAddrX = {8'h00, operand} + {8'h00, indexX_ff};
   assign indexedAddrY = {8'h00, operand} + {8'h00, indexY_ff};
   assign pcHighByte = progCount_ff[15:8];
   assign pcLowByte  = progCount_ff[7:0];

   assign isPush = (opSel == `CRS_OP_PHA) || (opSel == `CRS_OP_PHP);
   assign isPop  = (opSel == `CRS_OP_PLA) || (opSel == `CRS_OP_PLP);
   // Push writes at the current address before the pointer moves
   assign memWrite = isPush;
   assign memWriteData = (opSel == `CRS_OP_PHP) ? statusOut_ff : accumulator_ff;
   assign memRead = isPop;
   assign divZero = (indexX_ff == 8'h00);
   assign modeHit = modeWrite && (modeWriteAddr == `CRS_CPU_MODE_ADDR);
   assign productFull = accumulator_ff * indexX_ff;
   // Divide by zero gives all ones rather than an unknown result
   assign divideFull = divZero ? 16'hffff :
                       {accumulator_ff % indexX_ff, accumulator_ff / indexX_ff};

   // Program counter next value; a load beats an increment
   always @* begin
      nxt_progCount = progCount_ff;
      if (pcLoad) begin
         nxt_progCount = pcLoadValue;
      end else if (pcIncrement) begin
         nxt_progCount = progCount_ff + 16'h0001;
      end
   end

   always @* begin
      nxt_accumulator = accumulator_ff;
      case (opSel)
         `CRS_OP_LDA: nxt_accumulator = loadData;
         `CRS_OP_PLA: nxt_accumulator = memReadData;
         default:     nxt_accumulator = accumulator_ff;
      endcase
   end

   always @* begin
      nxt_indexX = indexX_ff;
      case (opSel)
         `CRS_OP_LDX: nxt_indexX = loadData;
         default:     nxt_indexX = indexX_ff;
      endcase
   end

   always @* begin
      nxt_indexY = indexY_ff;
      case (opSel)
         `CRS_OP_LDY: nxt_indexY = loadData;
         default:     nxt_indexY = indexY_ff;
      endcase
   end

   // Push moves down after its write, pop moves up before its read
   always @* begin
      nxt_stackPtr = stackPtr_ff;
      case (opSel)
         `CRS_OP_LDSP: nxt_stackPtr = loadData;
         `CRS_OP_PHA,
         `CRS_OP_PHP:  nxt_stackPtr = spMinusOne;
         `CRS_OP_PLA,
         `CRS_OP_PLP:  nxt_stackPtr = spPlusOne;
         default:      nxt_stackPtr = stackPtr_ff;
      endcase
   end

   // Idle cycles track the live status; a PLP pop overrides it
   always @* begin
      nxt_statusOut = statusOut_ff;
      case (opSel)
         `CRS_OP_PLP:  nxt_statusOut = memReadData;
         `CRS_OP_NONE,
         `CRS_OP_JUMP: nxt_statusOut = statusIn;
         default:      nxt_statusOut = statusOut_ff;
      endcase
   end

   // Writes to any other address leave the mode register alone
   always @* begin
      nxt_cpuModeReg = cpuModeReg_ff;
      if (modeHit) begin
         nxt_cpuModeReg = modeWriteData;
      end
   end

   // Request flags are single-cycle pulses
   always @* begin
      nxt_illegalOp = 1'b0;
      nxt_stopReq   = 1'b0;
      nxt_waitReq   = 1'b0;
      case (opSel)
         `CRS_OP_STOP: nxt_stopReq = 1'b1;
         `CRS_OP_WAIT: nxt_waitReq = 1'b1;
         `CRS_OP_FAST,
         `CRS_OP_SLOW: nxt_illegalOp = 1'b1;
         default:      nxt_illegalOp = 1'b0;
      endcase
   end

   always @* begin
      nxt_mulDivResult = mulDivResult_ff;
      case (opSel)
         `CRS_OP_MUL: nxt_mulDivResult = productFull;
         `CRS_OP_DIV: nxt_mulDivResult = divideFull;
         default:     nxt_mulDivResult = mulDivResult_ff;
      endcase
   end

   // Program counter
   always @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         progCount_ff <= `CRS_PC_RESET;
      end else begin
         progCount_ff <= nxt_progCount;
      end
   end

   // Data registers, stack and mode; holds come from the next-value logic
   always @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         accumulator_ff  <= 8'h00;
         indexX_ff       <= 8'h00;
         indexY_ff       <= 8'h00;
         stackPtr_ff     <= `CRS_SP_RESET;
         statusOut_ff    <= 8'h00;
         cpuModeReg_ff   <= `CRS_MODE_RESET;
         illegalOp_ff    <= 1'b0;
         stopReq_ff      <= 1'b0;
         waitReq_ff      <= 1'b0;
         mulDivResult_ff <= 16'h0000;
      end else begin
         accumulator_ff  <= nxt_accumulator;
         indexX_ff       <= nxt_indexX;
         indexY_ff       <= nxt_indexY;
         stackPtr_ff     <= nxt_stackPtr;
         statusOut_ff    <= nxt_statusOut;
         cpuModeReg_ff   <= nxt_cpuModeReg;
         illegalOp_ff    <= nxt_illegalOp;
         stopReq_ff      <= nxt_stopReq;
         waitReq_ff      <= nxt_waitReq;
         mulDivResult_ff <= nxt_mulDivResult;
      end
   end
endmodule

// ===== verif/crs_checker.sv
// Port assertions for the CPU register set
`include "crs_consts.vh"
module crs_checker (
   input wire logic        ref_clk, reset, pcIncrement, pcLoad, memWrite, memRead,
   input wire logic        illegalOp_ff, stopReq_ff,
   input wire logic [3:0]  opSel,
   input wire logic [7:0]  operand, memReadData, accumulator_ff, indexX_ff, indexY_ff,
   input wire logic [7:0]  stackPtr_ff, cpuModeReg_ff, pcHighByte, pcLowByte,
   input wire logic [15:0] stackAddr, indexedAddrX, indexedAddrY
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (reset);
   AST_STACK: assert property (stackAddr == {7'h00, cpuModeReg_ff[`CRS_STACK_PAGE_BIT],
      (memRead ? stackPtr_ff + 8'h01 : stackPtr_ff)}) else $error("stack address");
   AST_IDX_X: assert property (indexedAddrX == operand + indexX_ff) else $error("x index");
   AST_IDX_Y: assert property (indexedAddrY == operand + indexY_ff) else $error("y index");
   AST_PUSH: assert property (opSel == `CRS_OP_PHA |-> memWrite ##1
      stackPtr_ff == $past(stackPtr_ff) - 8'h01) else $error("push");
   AST_POP: assert property (opSel == `CRS_OP_PLA |-> memRead ##1
      accumulator_ff == $past(memReadData)) else $error("pop");
   AST_PC: assert property (pcIncrement && !pcLoad |=>
      {pcHighByte, pcLowByte} == $past({pcHighByte, pcLowByte}) + 16'h0001) else $error("pc");
   AST_ILLEGAL: assert property (opSel == `CRS_OP_FAST || opSel == `CRS_OP_SLOW
      |=> illegalOp_ff) else $error("illegal op");
   AST_STOP: assert property (opSel == `CRS_OP_STOP |=> stopReq_ff && !illegalOp_ff)
      else $error("stop");
endmodule
bind crs_cpu_register_set crs_checker chk_u (.ref_clk, .reset, .pcIncrement, .pcLoad,
   .memWrite, .memRead, .illegalOp_ff, .stopReq_ff, .opSel, .operand, .memReadData,
   .accumulator_ff, .indexX_ff, .indexY_ff, .stackPtr_ff, .cpuModeReg_ff, .pcHighByte,
   .pcLowByte, .stackAddr, .indexedAddrX, .indexedAddrY);

// ===== verif/crs_cpu_register_set_tb.sv
// Testbench for the CPU register set
`include "crs_consts.vh"
module crs_cpu_register_set_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic ref_clk = 0, reset = 1, pcIncrement = 0, pcLoad = 0, modeWrite = 0;
   logic [3:0] opSel = 0;
   logic [7:0] loadData = 0, statusIn = 8'h5a, operand = 0, modeWriteData = 0, memReadData = 0;
   logic [15:0] pcLoadValue = 0, modeWriteAddr = 0;
   wire [7:0] a, x, y, sp, st, md, ph, pl, wd;
   wire [15:0] sa, ix, iy, mdr;
   wire mw, mr, ill, stop_instr, wt;
   int n_errors = 0, cmp_count = 0, cyc = 0;
   crs_cpu_register_set dut_u (.ref_clk, .reset, .opSel, .loadData, .statusIn, .operand,
      .pcIncrement, .pcLoad, .pcLoadValue, .modeWrite, .modeWriteAddr, .modeWriteData,
      .memReadData, .accumulator_ff(a), .indexX_ff(x), .indexY_ff(y), .stackPtr_ff(sp),
      .statusOut_ff(st), .cpuModeReg_ff(md), .pcHighByte(ph), .pcLowByte(pl), .stackAddr(sa),
      .indexedAddrX(ix), .indexedAddrY(iy), .memWrite(mw), .memWriteData(wd), .memRead(mr),
      .illegalOp_ff(ill), .stopReq_ff(stop_instr), .waitReq_ff(wt), .mulDivResult_ff(mdr));
   always #5 ref_clk = ~ref_clk;
   task summarize;
      if (n_errors == 0 && cmp_count > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   task chk(input [15:0] g, input [15:0] e);
      cmp_count++;
      if (g !== e) begin
         n_errors++;
         $display("Error %0t: got %h want %h", $time, g, e);
      end
   endtask
   // Op applied at the edge between the two falling edges
   task op(input [3:0] c, input [7:0] d);
      @(negedge ref_clk);
      opSel = c;
      loadData = d;
      @(negedge ref_clk);
      opSel = `CRS_OP_NONE;
   endtask
   task t_regs;
      op(`CRS_OP_LDA, 8'h3c);
      op(`CRS_OP_LDX, 8'h05);
      op(`CRS_OP_LDY, 8'hf0);
      operand = 8'hff;
      #1 chk(a, 16'h003c);
      chk(ix, 16'h0104);
      chk(iy, 16'h01ef);
   endtask
   task t_ops;
      op(`CRS_OP_MUL, 8'h00);
      chk(mdr, 16'h012c);
      op(`CRS_OP_DIV, 8'h00);
      chk(mdr, 16'h000c);
      op(`CRS_OP_STOP, 8'h00);
      chk({stop_instr, ill}, 16'h0002);
      op(`CRS_OP_WAIT, 8'h00);
      chk(wt, 16'h0001);
      op(`CRS_OP_FAST, 8'h00);
      chk({ill, a}, 16'h013c);
      op(`CRS_OP_SLOW, 8'h00);
      chk(ill, 16'h0001);
   endtask
   task t_stack;
      chk(sp, 16'h00ff);
      @(negedge ref_clk);
      opSel = `CRS_OP_PHA;
      #1 chk(sa, 16'h00ff);
      chk({mw, wd}, 16'h013c);
      @(negedge ref_clk);
      opSel = `CRS_OP_NONE;
      modeWrite = 1;
      modeWriteAddr = 16'h003c;
      modeWriteData = 8'h04;
      chk(sp, 16'h00fe);
      @(negedge ref_clk);
      modeWriteAddr = 16'h003b;
      chk(sa, 16'h00fe);
      @(negedge ref_clk);
      modeWrite = 0;
      opSel = `CRS_OP_PLA;
      memReadData = 8'ha5;
      #1 chk(mr, 16'h0001);
      chk(sa, 16'h01ff);
      @(negedge ref_clk);
      opSel = `CRS_OP_NONE;
      chk({a, sp}, 16'ha5ff);
   endtask
   task t_status;
      op(`CRS_OP_LDSP, 8'h80);
      chk(sp, 16'h0080);
      @(negedge ref_clk);
      opSel = `CRS_OP_PHP;
      #1 chk({mw, wd}, 16'h015a);
      chk(sa, 16'h0180);
      @(negedge ref_clk);
      opSel = `CRS_OP_PLP;
      memReadData = 8'h3c;
      #1 chk(sa, 16'h0180);
      chk(mr, 16'h0001);
      @(negedge ref_clk);
      opSel = `CRS_OP_NONE;
      chk({st, sp}, 16'h3c80);
   endtask
   task t_pc;
      pcLoad = 1;
      pcLoadValue = 16'h12fe;
      @(negedge ref_clk);
      pcLoad = 0;
      pcIncrement = 1;
      repeat (2) @(negedge ref_clk);
      pcIncrement = 0;
      chk({ph, pl}, 16'h1300);
   endtask
   initial begin
      repeat (12) @(negedge ref_clk);
      reset = 0;
      t_regs;
      t_ops;
      t_stack;
      t_status;
      t_pc;
      summarize;
   end
   // Whole run needs well under a hundred cycles
   always @(posedge ref_clk) begin
      cyc++;
      if (cyc > 500) begin
         n_errors++;
         summarize;
      end
   end
endmodule
